//--- src/afe_timing_pkg.sv
// Constants, register map and types for the clamp and sample pulse timing
package afe_timing_pkg;

   localparam int DATA_W = 8;
   localparam int ADDR_W = 7;
   localparam int PHASE_W = 6;
   localparam int PHASES = 64;
   localparam int CLAMP_REF_W = 5;
   localparam int CNT_W = 4;

   // Register offsets
   localparam logic [ADDR_W-1:0] MAIN_CFG_ADDR = 7'h00;
   localparam logic [ADDR_W-1:0] CLAMP_REF_ADDR = 7'h04;
   localparam logic [ADDR_W-1:0] MON_SEL_ADDR = 7'h09;
   localparam logic [ADDR_W-1:0] CH1_GAIN_ADDR = 7'h10;
   localparam logic [ADDR_W-1:0] CH2_GAIN_ADDR = 7'h11;
   localparam logic [ADDR_W-1:0] CLAMP_START_ADDR = 7'h20;
   localparam logic [ADDR_W-1:0] CLAMP_END_ADDR = 7'h21;
   localparam logic [ADDR_W-1:0] SAMPLE_START_ADDR = 7'h22;
   localparam logic [ADDR_W-1:0] SAMPLE_END_ADDR = 7'h23;

   // Field positions
   localparam int CDS_EN_BIT = 0;
   localparam int CLAMP_GATE_BIT = 1;
   localparam int INPUT_GAIN_BIT = 2;
   localparam int MON_SEL_LSB = 3;
   localparam int MON_SEL_MSB = 4;
   localparam logic [1:0] MON_ODD_PULSES = 2'h2;

   // Reset values
   localparam logic [DATA_W-1:0] CFG_RESET = 8'h00;
   localparam logic [DATA_W-1:0] EDGE_RESET = 8'h00;

   // Serial frame: read flag, 7 address bits, 8 data bits, MSB first
   localparam logic [CNT_W-1:0] CMD_LAST = 4'h7;
   localparam logic [CNT_W-1:0] FRAME_LAST = 4'hf;

   // Edge zero lags the pixel clock rise by 6.0 ns plus 3 internal edges
   localparam int MCLK_PERIOD_PS = 10000;
   localparam int EDGE0_FIXED_PS = 6000;
   localparam int EDGE0_FRAC_EDGES = 3;
   localparam int EDGE0_LAG_CYC = (EDGE0_FIXED_PS + MCLK_PERIOD_PS - 1)
      / MCLK_PERIOD_PS + EDGE0_FRAC_EDGES;
   localparam logic [PHASE_W-1:0] PHASE_LOAD =
      PHASE_W'(PHASES - EDGE0_LAG_CYC + 1);
   localparam logic [PHASE_W-1:0] PHASE_LAST = 6'h3f;

   typedef enum logic [1:0] {
      SER_IDLE = 2'b00,
      SER_CMD = 2'b01,
      SER_DATA = 2'b10,
      SER_WAIT = 2'b11
   } ser_state_t;

endpackage

//--- src/pulse_window.sv
// Start/end edge window on the internal phase counter
`timescale 1ns/100ps
module pulse_window #(
   parameter int PHASE_W = 6
) (
   input wire logic [PHASE_W-1:0] phase,
   input wire logic [PHASE_W-1:0] startEdge,
   input wire logic [PHASE_W-1:0] endEdge,
   output logic active
);
   wire logic afterStart = phase >= startEdge;
   wire logic beforeEnd = phase < endEdge;
   wire logic wraps = startEdge > endEdge;

   // Wrapping window runs from start through the period boundary
   assign active = wraps ? (afterStart || beforeEnd)
                         : (afterStart && beforeEnd); // [R18] [R17]
endmodule

//--- src/clamp_sample_timing.sv
// Clamp and sample pulse timing with serial configuration registers
//
// Summary of operation
// R01 - CDS mode alternates even and odd sampling networks every pixel.
// R02 - One set of edge registers places even and odd pulses identically.
// R03 - Monitor select 10 puts odd clamp on test pin 0, sample on pin 1.
// R04 - Test pins then show odd pulses only, every second pixel; in sample-and-hold mode pin 1 shows the sample every pixel.
// R05 - Sample edges below clamp edges: sample falls in next period.
// R06 - Edge zero lags the pixel clock rise by 6.0 ns plus 3/64 period.
// R07 - The external clamp request closes the input clamp switch.
// R08 - With gating, clamp control is internal clamp AND external request.
// R09 - Host asserts the clamp request during optical black pixels.
// R10 - Host makes pulses wide and near the far edge of their level.
// R11 - Clamp reference DAC takes a five-bit code from its register.
// R12 - Main configuration bit 2 selects 0dB or 6dB for both channels.
// R13 - Each channel has its own eight-bit gain code register.
// R14 - Each pixel period has 64 internal edges; registers pick edges.
// R15 - In CDS clamp samples reference, sample takes video, same pixel.
// R16 - Sample-and-hold mode ignores the clamp start and end registers.
// R17 - Sample-and-hold start above end wraps into the next period.
// R18 - A pulse runs from its start edge up to its end edge.
// R19 - All configuration registers are 8 bits, serial read and write.
`timescale 1ns/100ps
module clamp_sample_timing (
   input wire logic mclk,
   input wire logic rst,
   input wire logic pixClk,
   input wire logic externalClampRequest,
   input wire logic serClk,
   input wire logic serSelN,
   input wire logic serDataIn,
   output logic serDataOut,
   output logic serDataOe,
   output logic gatedClampControl,
   output logic testMonitorPinZero,
   output logic testMonitorPinOne,
   output logic evenClampPulse,
   output logic oddClampPulse,
   output logic evenSamplePulse,
   output logic oddSamplePulse,
   output logic [afe_timing_pkg::CLAMP_REF_W-1:0] clampReferenceDacCode,
   output logic inputGain6dB,
   output logic [afe_timing_pkg::DATA_W-1:0] channelOneGain,
   output logic [afe_timing_pkg::DATA_W-1:0] channelTwoGain
);
   import afe_timing_pkg::*;

   // Configuration registers
   logic [DATA_W-1:0] mainConfiguration;
   logic [DATA_W-1:0] clampReferenceDacControl;
   logic [DATA_W-1:0] pulseMonitorSelect;
   logic [DATA_W-1:0] channelOneGainCode;
   logic [DATA_W-1:0] channelTwoGainCode;
   logic [DATA_W-1:0] clampStartEdge;
   logic [DATA_W-1:0] clampEndEdge;
   logic [DATA_W-1:0] sampleStartEdge;
   logic [DATA_W-1:0] sampleEndEdge;

   // Serial interface state
   ser_state_t serState;
   ser_state_t next_serState;
   logic serClkPrev;
   logic [CNT_W-1:0] bitCnt;
   logic [DATA_W-1:0] cmd;
   logic [DATA_W-1:0] dataSh;
   logic [DATA_W-1:0] outSh;

   // Pixel timing state
   logic pixClkPrev;
   logic [PHASE_W-1:0] phase;
   logic oddPixel;

   wire logic serRise = serClk && !serClkPrev;
   wire logic [DATA_W-1:0] cmdNext = {cmd[DATA_W-2:0], serDataIn};
   wire logic [DATA_W-1:0] dataNext = {dataSh[DATA_W-2:0], serDataIn};
   wire logic cmdDone = serState == SER_CMD && serRise && bitCnt == CMD_LAST;
   wire logic frameDone = serState == SER_DATA && serRise
      && bitCnt == FRAME_LAST;
   wire logic wrStrobe = frameDone && !cmd[DATA_W-1]; // [R19]
   wire logic [ADDR_W-1:0] wrAddr = cmd[ADDR_W-1:0];
   wire logic [ADDR_W-1:0] rdAddr = cmdNext[ADDR_W-1:0];

   // Unmapped offsets read as zero and ignore writes
   wire logic [DATA_W-1:0] rdData =
      rdAddr == MAIN_CFG_ADDR ? mainConfiguration :
      rdAddr == CLAMP_REF_ADDR ? clampReferenceDacControl :
      rdAddr == MON_SEL_ADDR ? pulseMonitorSelect :
      rdAddr == CH1_GAIN_ADDR ? channelOneGainCode :
      rdAddr == CH2_GAIN_ADDR ? channelTwoGainCode :
      rdAddr == CLAMP_START_ADDR ? clampStartEdge :
      rdAddr == CLAMP_END_ADDR ? clampEndEdge :
      rdAddr == SAMPLE_START_ADDR ? sampleStartEdge :
      rdAddr == SAMPLE_END_ADDR ? sampleEndEdge : 8'h00; // [R19]

   always_comb begin
      next_serState = serState;
      case (serState)
         SER_IDLE: if (!serSelN) next_serState = SER_CMD;
         SER_CMD: if (cmdDone) next_serState = SER_DATA;
         SER_DATA: if (frameDone) next_serState = SER_WAIT;
         SER_WAIT: next_serState = SER_WAIT;
         default: next_serState = SER_IDLE;
      endcase
      // Deselect aborts any frame; a partial write is dropped
      if (serSelN) next_serState = SER_IDLE;
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         serState <= SER_IDLE;
         serClkPrev <= 1'b0;
         bitCnt <= '0;
         cmd <= '0;
         dataSh <= '0;
      end else begin
         serState <= next_serState;
         serClkPrev <= serClk;
         if (serState == SER_IDLE) begin
            bitCnt <= '0;
         end else if (serRise) begin
            bitCnt <= bitCnt + 4'h1;
         end
         if (serState == SER_CMD && serRise) cmd <= cmdNext;
         if (serState == SER_DATA && serRise) dataSh <= dataNext;
      end
   end

   // Read data leaves MSB first, changing after each serial clock rise
   always_ff @(posedge mclk) begin
      if (rst) begin
         outSh <= '0;
         serDataOut <= 1'b0;
         serDataOe <= 1'b0;
      end else begin
         if (cmdDone) begin
            serDataOut <= rdData[DATA_W-1];
            outSh <= {rdData[DATA_W-2:0], 1'b0};
         end else if (serState == SER_DATA && serRise) begin
            serDataOut <= outSh[DATA_W-1];
            outSh <= {outSh[DATA_W-2:0], 1'b0};
         end
         serDataOe <= next_serState == SER_DATA && (cmdDone ? cmdNext[DATA_W-1]
                                                            : cmd[DATA_W-1]);
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         mainConfiguration <= CFG_RESET;
         clampReferenceDacControl <= CFG_RESET;
         pulseMonitorSelect <= CFG_RESET;
         channelOneGainCode <= CFG_RESET;
         channelTwoGainCode <= CFG_RESET;
         clampStartEdge <= EDGE_RESET;
         clampEndEdge <= EDGE_RESET;
         sampleStartEdge <= EDGE_RESET;
         sampleEndEdge <= EDGE_RESET;
      end else if (wrStrobe) begin // [R19]
         if (wrAddr == MAIN_CFG_ADDR) mainConfiguration <= dataNext;
         if (wrAddr == CLAMP_REF_ADDR) clampReferenceDacControl <= dataNext;
         if (wrAddr == MON_SEL_ADDR) pulseMonitorSelect <= dataNext;
         if (wrAddr == CH1_GAIN_ADDR) channelOneGainCode <= dataNext;
         if (wrAddr == CH2_GAIN_ADDR) channelTwoGainCode <= dataNext;
         if (wrAddr == CLAMP_START_ADDR) clampStartEdge <= dataNext;
         if (wrAddr == CLAMP_END_ADDR) clampEndEdge <= dataNext;
         if (wrAddr == SAMPLE_START_ADDR) sampleStartEdge <= dataNext;
         if (wrAddr == SAMPLE_END_ADDR) sampleEndEdge <= dataNext;
      end
   end

   // Register fields that steer the analog side
   assign clampReferenceDacCode =
      clampReferenceDacControl[CLAMP_REF_W-1:0]; // [R11]
   assign inputGain6dB = mainConfiguration[INPUT_GAIN_BIT]; // [R12]
   assign channelOneGain = channelOneGainCode; // [R13]
   assign channelTwoGain = channelTwoGainCode; // [R13]

   wire logic cdsMode = mainConfiguration[CDS_EN_BIT];
   wire logic clampGateEn = mainConfiguration[CLAMP_GATE_BIT];
   wire logic [1:0] monSel = pulseMonitorSelect[MON_SEL_MSB:MON_SEL_LSB];

   // One mclk cycle is one internal edge, so mclk runs at 64x pixel rate
   wire logic pixRise = pixClk && !pixClkPrev;

   always_ff @(posedge mclk) begin
      if (rst) begin
         pixClkPrev <= 1'b0;
         phase <= '0;
         oddPixel <= 1'b0;
      end else begin
         pixClkPrev <= pixClk;
         // Realign every pixel so edge zero trails the input rise
         if (pixRise) begin
            phase <= PHASE_LOAD; // [R06]
         end else begin
            phase <= phase + 6'h01; // [R14]
         end
         if (phase == PHASE_LAST) oddPixel <= !oddPixel; // [R01]
      end
   end

   logic clampWin;
   logic sampleWin;

   // Only the low six bits address the 64 edges
   pulse_window #(.PHASE_W(PHASE_W)) clampWindow (
      .phase(phase),
      .startEdge(clampStartEdge[PHASE_W-1:0]),
      .endEdge(clampEndEdge[PHASE_W-1:0]),
      .active(clampWin)
   ); // [R02] [R14]

   pulse_window #(.PHASE_W(PHASE_W)) sampleWindow (
      .phase(phase),
      .startEdge(sampleStartEdge[PHASE_W-1:0]),
      .endEdge(sampleEndEdge[PHASE_W-1:0]),
      .active(sampleWin)
   ); // [R02] [R14]

   // Sample edges below clamp edges belong to the previous pixel
   wire logic lateSample = cdsMode
      && sampleStartEdge[PHASE_W-1:0] < clampStartEdge[PHASE_W-1:0]
      && sampleEndEdge[PHASE_W-1:0] < clampEndEdge[PHASE_W-1:0]; // [R05]
   wire logic sampleOddNet = cdsMode && (lateSample ? !oddPixel : oddPixel);
   wire logic clampInt = cdsMode && clampWin; // [R16] [R15]
   wire logic oddClampInt = clampInt && oddPixel; // [R01]
   wire logic evenClampInt = clampInt && !oddPixel; // [R01]
   // Sample-and-hold has one network, reported on the odd side
   wire logic oddSampleInt = sampleWin && (sampleOddNet || !cdsMode);
   wire logic evenSampleInt = sampleWin && cdsMode && !sampleOddNet;
   wire logic monOdd = monSel == MON_ODD_PULSES;
   wire logic next_gatedClamp = clampGateEn
      ? externalClampRequest && clampInt // [R08]
      : externalClampRequest; // [R07]

   always_ff @(posedge mclk) begin
      if (rst) begin
         evenClampPulse <= 1'b0;
         oddClampPulse <= 1'b0;
         evenSamplePulse <= 1'b0;
         oddSamplePulse <= 1'b0;
         testMonitorPinZero <= 1'b0;
         testMonitorPinOne <= 1'b0;
         gatedClampControl <= 1'b0;
      end else begin
         evenClampPulse <= evenClampInt;
         oddClampPulse <= oddClampInt;
         evenSamplePulse <= evenSampleInt; // [R15]
         oddSamplePulse <= oddSampleInt;
         testMonitorPinZero <= monOdd && oddClampInt; // [R03] [R04]
         testMonitorPinOne <= monOdd && oddSampleInt; // [R03] [R04]
         gatedClampControl <= next_gatedClamp;
      end
   end

   // Checks
   // Cycles from the last of three quiet edges to edge zero
   localparam int LAG_TAIL = EDGE0_LAG_CYC - 3;

   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   net_alternate_a: assert property ( // [R01]
      phase == PHASE_LAST |=> oddPixel != $past(oddPixel))
      else $error("network did not alternate at pixel boundary");

   shared_edges_a: assert property ( // [R02]
      cdsMode && clampWin |=> evenClampPulse != oddClampPulse)
      else $error("clamp window not placed on exactly one network");

   monitor_route_a: assert property ( // [R03]
      monOdd && oddClampInt && $stable(monOdd)
      |=> testMonitorPinZero)
      else $error("odd clamp missing on test pin zero");

   monitor_odd_a: assert property ( // [R04]
      testMonitorPinZero |-> oddClampPulse && !evenClampPulse)
      else $error("test pin zero shows a non-odd clamp");

   late_sample_a: assert property ( // [R05]
      lateSample && sampleWin && $stable(oddPixel) && oddPixel
      |=> evenSamplePulse && !oddSamplePulse)
      else $error("late sample not credited to previous pixel");

   edge_zero_a: assert property ( // [R06]
      pixRise ##1 !pixRise [*3] |-> ##[LAG_TAIL:LAG_TAIL] phase == '0)
      else $error("edge zero lag wrong");

   gate_and_a: assert property ( // [R08]
      clampGateEn && $stable(clampGateEn)
      |=> gatedClampControl == $past(externalClampRequest && clampInt))
      else $error("gated clamp is not the AND");

   direct_clamp_a: assert property ( // [R07]
      !clampGateEn ##1 !clampGateEn
      |-> gatedClampControl == $past(externalClampRequest))
      else $error("clamp request not passed through");

   sh_no_clamp_a: assert property ( // [R16]
      !cdsMode ##1 !cdsMode |-> !evenClampPulse && !oddClampPulse)
      else $error("clamp pulse in sample-and-hold mode");

   wrap_window_a: assert property ( // [R17]
      sampleStartEdge[PHASE_W-1:0] > sampleEndEdge[PHASE_W-1:0]
      && phase == sampleStartEdge[PHASE_W-1:0] |-> sampleWin)
      else $error("wrapping sample window missing at start");

   dac_code_a: assert property ( // [R11]
      wrStrobe && wrAddr == CLAMP_REF_ADDR
      |=> clampReferenceDacCode == $past(dataNext[CLAMP_REF_W-1:0]))
      else $error("clamp reference code not updated");

   gain_bit_a: assert property ( // [R12]
      wrStrobe && wrAddr == MAIN_CFG_ADDR
      |=> inputGain6dB == $past(dataNext[INPUT_GAIN_BIT]))
      else $error("input gain bit not updated");

   cover_cds_pair_c: cover property (
      cdsMode ##1 oddClampPulse ##[1:64] oddSamplePulse);
   cover_late_c: cover property (lateSample && evenSamplePulse);
   cover_monitor_c: cover property (testMonitorPinZero ##[1:64]
      testMonitorPinOne);
   cover_read_c: cover property (serDataOe && frameDone);
endmodule

//--- dv/pixel_source_model.sv
// Sensor side model: pixel clock and optical black clamp request
`timescale 1ns/100ps
module pixel_source_model #(
   parameter int PIX_CYCLES = 64,
   parameter int LINE_PIXELS = 8,
   parameter int BLACK_PIXELS = 3
) (
   input wire logic mclk,
   input wire logic rst,
   output logic pixClk,
   output logic externalClampRequest
);
   int cyc = 0;
   int pix = 0;

   initial begin
      pixClk = 1'b0;
      externalClampRequest = 1'b0;
   end

   // Launched off the falling edge so the block samples settled levels
   always @(negedge mclk) begin
      if (rst) begin
         cyc <= 0;
         pix <= 0;
         pixClk <= 1'b0;
         externalClampRequest <= 1'b0;
      end else begin
         cyc <= (cyc + 1) % PIX_CYCLES;
         if (cyc == PIX_CYCLES - 1)
            pix <= (pix + 1) % LINE_PIXELS;
         pixClk <= (cyc < PIX_CYCLES / 2);
         // Request only over the first pixels of a line, the black ones
         externalClampRequest <= (pix < BLACK_PIXELS);
      end
   end
endmodule

//--- dv/clamp_sample_timing_tb_top.sv
// Testbench for the clamp and sample pulse timing block
`timescale 1ns/100ps
module clamp_sample_timing_tb_top;
   import afe_timing_pkg::*;
   logic mclk, rst, pixClk, externalClampRequest;
   logic serClk, serSelN, serDataIn, serDataOut, serDataOe;
   logic gatedClampControl, testMonitorPinZero, testMonitorPinOne;
   logic evenClampPulse, oddClampPulse, evenSamplePulse, oddSamplePulse;
   logic [CLAMP_REF_W-1:0] clampReferenceDacCode;
   logic inputGain6dB;
   logic [DATA_W-1:0] channelOneGain, channelTwoGain;
   logic [7:0] cfg, cs, ce, ss, se, monSel;
   logic watchOn, pixPrev, reqAtEdge, oc, os, prevOc;
   int fail_count = 0;
   int checked = 0;
   int ph = -1;
   int pixCnt = 0;
   logic [6:0] addrs [9] = '{MAIN_CFG_ADDR, CLAMP_REF_ADDR, MON_SEL_ADDR,
      CH1_GAIN_ADDR, CH2_GAIN_ADDR, CLAMP_START_ADDR, CLAMP_END_ADDR,
      SAMPLE_START_ADDR, SAMPLE_END_ADDR};
   logic [7:0] pats [9] = '{8'h04, 8'hf3, 8'h18, 8'h5a, 8'hc3, 8'h81,
      8'h42, 8'h24, 8'hff};

   clamp_sample_timing i_dut (.mclk(mclk), .rst(rst), .pixClk(pixClk),
      .externalClampRequest(externalClampRequest), .serClk(serClk),
      .serSelN(serSelN), .serDataIn(serDataIn), .serDataOut(serDataOut),
      .serDataOe(serDataOe), .gatedClampControl(gatedClampControl),
      .testMonitorPinZero(testMonitorPinZero),
      .testMonitorPinOne(testMonitorPinOne),
      .evenClampPulse(evenClampPulse), .oddClampPulse(oddClampPulse),
      .evenSamplePulse(evenSamplePulse), .oddSamplePulse(oddSamplePulse),
      .clampReferenceDacCode(clampReferenceDacCode),
      .inputGain6dB(inputGain6dB), .channelOneGain(channelOneGain),
      .channelTwoGain(channelTwoGain));

   pixel_source_model i_sensor (.mclk(mclk), .rst(rst), .pixClk(pixClk),
      .externalClampRequest(externalClampRequest));

   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   task automatic check(input string what, input logic [7:0] seen,
         input logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic complete_run;
      $display("Checks %0d, mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // One full serial frame; each serClk level is held two mclk cycles
   task automatic ser(input logic rd, input logic [6:0] a,
         input logic [7:0] wd, output logic [7:0] rdat);
      logic [15:0] fr;
      fr = {rd, a, wd};
      rdat = 8'h00;
      serSelN = 1'b0;
      for (int i = 0; i < 16; i++) begin
         serDataIn = fr[15-i];
         repeat (2) @(negedge mclk);
         if (i >= 8 && rd) begin
            rdat[15-i] = serDataOut;
            check("read enable", serDataOe, 8'h01);
         end
         serClk = 1'b1;
         repeat (2) @(negedge mclk);
         serClk = 1'b0;
      end
      repeat (2) @(negedge mclk);
      serSelN = 1'b1;
      repeat (2) @(negedge mclk);
      check("idle enable", serDataOe, 8'h00);
   endtask

   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      logic [7:0] r;
      ser(1'b0, a, d, r);
   endtask

   task automatic rdchk(input logic [6:0] a, input logic [7:0] exp);
      logic [7:0] r;
      ser(1'b1, a, 8'h00, r);
      check("readback", r, exp);
   endtask

   // Program the edges and mode, let two pixels pass, then watch ten
   task automatic scen(input logic [7:0] c, a, b, d, e, m);
      watchOn = 1'b0;
      cfg = c;
      cs = a;
      ce = b;
      ss = d;
      se = e;
      monSel = m;
      wr(CLAMP_START_ADDR, a);
      wr(CLAMP_END_ADDR, b);
      wr(SAMPLE_START_ADDR, d);
      wr(SAMPLE_END_ADDR, e);
      wr(MON_SEL_ADDR, m);
      wr(MAIN_CFG_ADDR, c);
      repeat (128) @(negedge mclk);
      @(posedge mclk);
      pixCnt = 0;
      watchOn = 1'b1;
      repeat (640) @(negedge mclk);
   endtask

   function automatic logic inWin(int p, logic [7:0] s, logic [7:0] e);
      if (s[5:0] <= e[5:0])
         return (p >= s[5:0]) && (p < e[5:0]);
      return (p >= s[5:0]) || (p < e[5:0]);
   endfunction

   always @(posedge mclk) begin
      pixPrev <= pixClk;
      reqAtEdge <= externalClampRequest;
      if (pixClk && !pixPrev)
         ph <= 0;
      else if (ph >= 0)
         ph <= ph + 1;
   end

   // Edge zero comes one cycle less than EDGE0_LAG_CYC after ph restarts; the output register adds one
   always @(negedge mclk) begin
      int p;
      logic anyC, anyS, mon;
      p = (ph - EDGE0_LAG_CYC) & 63;
      anyC = evenClampPulse | oddClampPulse;
      anyS = evenSamplePulse | oddSamplePulse;
      mon = (monSel[4:3] == MON_ODD_PULSES);
      if (watchOn && ph >= 0) begin
         check("clamp", anyC, cfg[0] & inWin(p, cs, ce));
         check("sample", anyS, inWin(p, ss, se));
         check("pin zero", testMonitorPinZero, mon & oddClampPulse);
         check("pin one", testMonitorPinOne, mon & oddSamplePulse);
         check("gated", gatedClampControl,
            cfg[1] ? anyC & reqAtEdge : reqAtEdge);
         if (p == 0) begin
            if (pixCnt >= 3 && cfg[0]) begin
               check("odd alternate", oc, !prevOc);
               // Only the low six edge bits count
               check("odd sample", os, (ss[5:0] < cs[5:0]
                  && se[5:0] < ce[5:0]) ? prevOc : oc);
            end
            if (pixCnt >= 3 && !cfg[0])
               check("hold sample", os, 8'h01);
            prevOc = oc;
            oc = 1'b0;
            os = 1'b0;
            pixCnt++;
         end
         oc = oc | oddClampPulse;
         os = os | oddSamplePulse;
      end
   end

   initial begin
      rst = 1'b1;
      serClk = 1'b0;
      serSelN = 1'b1;
      serDataIn = 1'b0;
      watchOn = 1'b0;
      cfg = 8'h00;
      monSel = 8'h00;
      oc = 1'b0;
      os = 1'b0;
      prevOc = 1'b0;
      repeat (16) @(negedge mclk);
      rst = 1'b0;
      @(negedge mclk);
      foreach (addrs[i]) rdchk(addrs[i], 8'h00);
      foreach (addrs[i]) wr(addrs[i], pats[i]);
      foreach (addrs[i]) rdchk(addrs[i], pats[i]);
      wr(7'h05, 8'hff);
      rdchk(7'h05, 8'h00);
      check("dac code", clampReferenceDacCode, 8'h13);
      check("input gain", inputGain6dB, 8'h01);
      check("gain one", channelOneGain, 8'h5a);
      check("gain two", channelTwoGain, 8'hc3);
      wr(MAIN_CFG_ADDR, 8'h00);
      check("input gain", inputGain6dB, 8'h00);
      // Wide pulses near the far end of each level
      scen(8'h01, 8'h08, 8'h14, 8'h1e, 8'h32, 8'h10);
      scen(8'h03, 8'h1e, 8'h32, 8'h05, 8'h14, 8'h10);
      scen(8'h00, 8'h08, 8'h14, 8'h32, 8'h0a, 8'h10);
      scen(8'h03, 8'hc8, 8'h54, 8'h5e, 8'h72, 8'h08);
      complete_run();
   end

   initial begin
      #500000;
      fail_count++;
      complete_run();
   end
endmodule
